// file: vcc_map.vh
// Register map, field positions and reset values of the voltage comparator control block
// Assumes word-aligned Avalon-MM byte addressing with 32-bit data, 8 bits used per register
`ifndef VCC_MAP_VH
`define VCC_MAP_VH

// Byte offsets
`define VCC_ANALOG_ENABLE_OFS  4'h0
`define VCC_CTRL_OFS           4'h4
`define VCC_STATUS_OFS         4'h8
`define VCC_INT_OFS            4'hC

// Field positions
`define VCC_CMP_EN_BIT         7
`define VCC_RESULT_BIT         7
`define VCC_PAD_OE_BIT         6
`define VCC_INT_FLAG_BIT       0
`define VCC_INT_EN_BIT         1

// Reset values
`define VCC_ANALOG_ENABLE_RST  8'h00
`define VCC_CTRL_RST           8'h00
`define VCC_STATUS_RST         8'h00

// Number of synchroniser stages on the analog result
`define VCC_SYNC_STAGES        2

`endif

// file: vcc_comparator_ctrl.v
// Digital control around one analog voltage comparator: enable, mode, input routing,
// registered result, change flag and pad output override.
// Assumes one clock, an Avalon-MM master, and analog switches driven by the select outputs.
//
// Overview of operation
// - Comparator powered only while comparator_enable bit 7 is set; resets off.
// - Halt input forces comparator off regardless of the enable bit.
// - Level code zero gives pad-to-pad mode, codes one to fifteen pad-to-reference.
// - Pad-to-reference inverting input is reference n/16 of supply.
// - Pad-to-reference non-inverting input from pad code; 1110 and 1111 select nothing.
// - Pad-to-pad codes 0000-0011 pair A0/A1, A1/A0, A2/A3, A3/A2.
// - Pad-to-pad codes 0100-1011 pair port A with port B lines, 1100-1111 port B lines with each other, per table.
// - Change flag sets when live result differs from its registered copy.
// - Reading the output status register loads the live result into the copy.
// - Result readable at bit 7 of the output status register.
// - Pad output enable drives port B line 3 with the live result.
// - Pad output enable disables the PWM channel one output.
//
// Register map, byte offsets on a 32-bit word bus, low byte used:
//   0x0 analog enable, bit 7 comparator enable
//   0x4 comparator control, bits 7:4 pad code, bits 3:0 level code
//   0x8 output status, bit 7 live result (read only), bit 6 pad output enable
//   0xC interrupt, bit 0 change flag (write 0 clears), bit 1 change interrupt enable
// Unmapped offsets read zero and ignore writes; byte lane 0 gates every write.
// Every access takes one wait state; the acknowledge cycle follows acceptance.
// Select vectors: bits 0-7 are port A lines 0-7, bits 8-13 port B lines 0-5.
// Limitation: a result pulse shorter than one clock period may be missed.
`timescale 1ns/1ps
`include "vcc_map.vh"

module vcc_comparator_ctrl #(
   parameter SYNC_STAGES = `VCC_SYNC_STAGES
) (
   input  wire        clk,
   input  wire        nrst,
   // Avalon-MM slave
   input  wire [3:0]  address,
   input  wire        read,
   input  wire        write,
   input  wire [31:0] writedata,
   input  wire [3:0]  byteenable,
   output reg  [31:0] readdata,
   output wire        waitrequest,
   // Core and analog side
   input  wire        haltMode,
   input  wire        cmpRawOut,
   input  wire        pwmChannelOneIn,
   output wire        cmpPowerOn,
   output wire        padToPadMode,
   output wire        padToRefMode,
   output reg  [3:0]  refLevel,
   output reg         posSelValid,
   output reg  [13:0] posPadSel,
   output reg  [13:0] negPadSel,
   output reg         portBLine3Out,
   output reg         portBLine3Oe,
   output wire        pwmChannelOneOut,
   output wire        cmpIntFlagOut
);

   // Bus answer states, one-hot
   localparam ST_IDLE = 2'h1;
   localparam ST_ACK  = 2'h2;

   // Register contents, result copy, synchroniser and bus state
   reg [7:0]             analogEnableReg;
   reg [7:0]             ctrlReg;
   reg                   padOe;
   reg                   intEn;
   reg                   intFlag;
   reg                   resultCopy;
   reg [SYNC_STAGES-1:0] syncChain;
   reg [1:0]             state;
   reg [1:0]             next_state;
   reg [31:0]            next_readdata;

   // Field views and bus decode
   wire       liveResult = syncChain[SYNC_STAGES-1];
   wire [3:0] levelSel   = ctrlReg[3:0];
   wire [3:0] padSel     = ctrlReg[7:4];
   wire       accept     = (state == ST_IDLE) && (read || write);
   wire       doWrite    = accept && write && byteenable[0];
   wire       statusRead = accept && read && (address == `VCC_STATUS_OFS);

   // One wait state per access, then the acknowledge cycle
   assign waitrequest = (state != ST_ACK);

   // Next state: a request seen in idle always moves to acknowledge
   always @* begin
      case (state)
         ST_IDLE: next_state = (read || write) ? ST_ACK : ST_IDLE;
         ST_ACK:  next_state = ST_IDLE;
         default: next_state = ST_IDLE;
      endcase
   end

   // Bus state register
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Synchroniser: only the next stage reads each earlier stage
   // A metastable first stage never reaches the flag or the pad output
   genvar gi;
   generate
      for (gi = 0; gi < SYNC_STAGES; gi = gi + 1) begin : gSync
         always @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               syncChain[gi] <= 1'h0;
            end else if (gi == 0) begin
               syncChain[gi] <= cmpRawOut;
            end else begin
               syncChain[gi] <= syncChain[(gi == 0) ? 0 : gi - 1];
            end
         end
      end
   endgenerate

   // Register writes, registered result and change flag
   // A write without byte lane 0 changes nothing
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         analogEnableReg <= `VCC_ANALOG_ENABLE_RST;
         ctrlReg         <= `VCC_CTRL_RST;
         padOe           <= 1'h0;
         intEn           <= 1'h0;
         intFlag         <= 1'h0;
         resultCopy      <= 1'h0;
      end else begin
         if (doWrite && address == `VCC_ANALOG_ENABLE_OFS) begin
            analogEnableReg <= writedata[7:0];
         end
         if (doWrite && address == `VCC_CTRL_OFS) begin
            ctrlReg <= writedata[7:0];
         end
         if (doWrite && address == `VCC_STATUS_OFS) begin
            padOe <= writedata[`VCC_PAD_OE_BIT];
         end
         if (doWrite && address == `VCC_INT_OFS) begin
            intEn <= writedata[`VCC_INT_EN_BIT];
         end
         // Status read refreshes the copy, ending the mismatch
         if (statusRead) begin
            resultCopy <= liveResult;
         end
         // Set wins over a software clear in the same cycle
         // The flag keeps setting until a status read refreshes the copy
         if (liveResult != resultCopy) begin
            intFlag <= 1'h1;
         end else if (doWrite && address == `VCC_INT_OFS
                      && !writedata[`VCC_INT_FLAG_BIT]) begin
            intFlag <= 1'h0;
         end
      end
   end

   // Read data captured at acceptance, shown during the acknowledge cycle
   always @* begin
      next_readdata = 32'h00000000;
      case (address)
         `VCC_ANALOG_ENABLE_OFS: next_readdata[7:0] = analogEnableReg;
         `VCC_CTRL_OFS:          next_readdata[7:0] = ctrlReg;
         `VCC_STATUS_OFS: begin
            next_readdata[`VCC_RESULT_BIT] = liveResult;
            next_readdata[`VCC_PAD_OE_BIT] = padOe;
         end
         `VCC_INT_OFS: begin
            next_readdata[`VCC_INT_FLAG_BIT] = intFlag;
            next_readdata[`VCC_INT_EN_BIT]   = intEn;
         end
         default: next_readdata = 32'h00000000;
      endcase
   end

   // Read data register; holds its value until the next read
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         readdata <= 32'h00000000;
      end else if (accept && read) begin
         readdata <= next_readdata;
      end
   end

   // Power and mode decode
   // Halt removes power at once, whatever the enable bit holds
   assign cmpPowerOn    = analogEnableReg[`VCC_CMP_EN_BIT] && !haltMode;
   assign padToPadMode  = (levelSel == 4'h0);
   assign padToRefMode  = !padToPadMode;
   assign cmpIntFlagOut = intFlag && intEn;

   // Input routing; bits 0-7 are port A lines 0-7, bits 8-13 port B lines 0-5
   // Registered so the analog switches never see a decode glitch
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         refLevel    <= 4'h0;
         posSelValid <= 1'h0;
         posPadSel   <= 14'h0000;
         negPadSel   <= 14'h0000;
      end else begin
         refLevel  <= levelSel;
         posPadSel <= 14'h0000;
         negPadSel <= 14'h0000;
         if (padToRefMode) begin
            posSelValid <= (padSel < 4'hE);
            if (padSel < 4'hE) begin
               posPadSel[padSel] <= 1'h1;
            end
         end else begin
            // Pad pairs, non-inverting input first
            posSelValid <= 1'h1;
            case (padSel)
               4'h0: begin
                  posPadSel[0]  <= 1'h1;
                  negPadSel[1]  <= 1'h1;
               end
               4'h1: begin
                  posPadSel[1]  <= 1'h1;
                  negPadSel[0]  <= 1'h1;
               end
               4'h2: begin
                  posPadSel[2]  <= 1'h1;
                  negPadSel[3]  <= 1'h1;
               end
               4'h3: begin
                  posPadSel[3]  <= 1'h1;
                  negPadSel[2]  <= 1'h1;
               end
               4'h4: begin
                  posPadSel[0]  <= 1'h1;
                  negPadSel[11] <= 1'h1;
               end
               4'h5: begin
                  posPadSel[1]  <= 1'h1;
                  negPadSel[10] <= 1'h1;
               end
               4'h6: begin
                  posPadSel[2]  <= 1'h1;
                  negPadSel[13] <= 1'h1;
               end
               4'h7: begin
                  posPadSel[3]  <= 1'h1;
                  negPadSel[12] <= 1'h1;
               end
               4'h8: begin
                  posPadSel[10] <= 1'h1;
                  negPadSel[1]  <= 1'h1;
               end
               4'h9: begin
                  posPadSel[11] <= 1'h1;
                  negPadSel[0]  <= 1'h1;
               end
               4'hA: begin
                  posPadSel[12] <= 1'h1;
                  negPadSel[3]  <= 1'h1;
               end
               4'hB: begin
                  posPadSel[13] <= 1'h1;
                  negPadSel[2]  <= 1'h1;
               end
               4'hC: begin
                  posPadSel[10] <= 1'h1;
                  negPadSel[11] <= 1'h1;
               end
               4'hD: begin
                  posPadSel[11] <= 1'h1;
                  negPadSel[10] <= 1'h1;
               end
               4'hE: begin
                  posPadSel[12] <= 1'h1;
                  negPadSel[13] <= 1'h1;
               end
               default: begin
                  posPadSel[13] <= 1'h1;
                  negPadSel[12] <= 1'h1;
               end
            endcase
         end
      end
   end

   // Pad output of the live result; enable low while driving
   // Reset leaves the pad released so the port logic keeps it
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         portBLine3Out <= 1'h0;
         portBLine3Oe  <= 1'h1;
      end else begin
         portBLine3Out <= liveResult;
         portBLine3Oe  <= !padOe;
      end
   end

   // PWM channel one is blocked while the pad output is on
   assign pwmChannelOneOut = pwmChannelOneIn && !padOe;

endmodule

// file: vcc_comparator_ctrl_chk.sv
// Checker for the comparator control block, bound to its ports
// Assumes one clock domain and the fixed one-wait-state bus answer
`timescale 1ns/1ps

module vcc_comparator_ctrl_chk #(
   parameter SYNC_STAGES = 2
) (
   input wire        clk,
   input wire        nrst,
   input wire        read,
   input wire        write,
   input wire        waitrequest,
   input wire        haltMode,
   input wire        cmpRawOut,
   input wire        cmpPowerOn,
   input wire        padToPadMode,
   input wire        padToRefMode,
   input wire [3:0]  refLevel,
   input wire        posSelValid,
   input wire [13:0] posPadSel,
   input wire [13:0] negPadSel,
   input wire        portBLine3Out,
   input wire        portBLine3Oe,
   input wire        pwmChannelOneOut
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   // Power, mode and routing relations
   a_halt_off: assert property (haltMode |-> !cmpPowerOn)
      else $error("comparator powered in halt");
   a_mode_excl: assert property (padToPadMode != padToRefMode)
      else $error("both or neither mode");
   a_ref_level: assert property (padToRefMode |=> refLevel != 4'h0 && negPadSel == 14'h0)
      else $error("reference mode routing wrong");
   a_pad_pairs: assert property (padToPadMode |=> $onehot(negPadSel) && refLevel == 4'h0)
      else $error("pad pair routing wrong");
   a_pos_onehot: assert property (posSelValid |-> $onehot(posPadSel))
      else $error("positive select not one-hot");

   // Pad override and bus answer
   a_pwm_block: assert property (!portBLine3Oe [*2] |-> !$past(pwmChannelOneOut))
      else $error("pwm output while pad overridden");
   a_pad_follow: assert property (!portBLine3Oe |->
      portBLine3Out == $past(cmpRawOut, SYNC_STAGES + 1))
      else $error("pad not following result");
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
endmodule

bind vcc_comparator_ctrl vcc_comparator_ctrl_chk #(.SYNC_STAGES(SYNC_STAGES)) i_chk (
   .clk(clk), .nrst(nrst), .read(read), .write(write), .waitrequest(waitrequest),
   .haltMode(haltMode), .cmpRawOut(cmpRawOut), .cmpPowerOn(cmpPowerOn),
   .padToPadMode(padToPadMode), .padToRefMode(padToRefMode), .refLevel(refLevel),
   .posSelValid(posSelValid), .posPadSel(posPadSel), .negPadSel(negPadSel),
   .portBLine3Out(portBLine3Out), .portBLine3Oe(portBLine3Oe),
   .pwmChannelOneOut(pwmChannelOneOut));

// file: vcc_comparator_ctrl_tb_top.sv
// Self-checking bench for the comparator control block
// Assumes the register map header and a 40 MHz clock
`timescale 1ns/1ps
`include "vcc_map.vh"

module vcc_comparator_ctrl_tb_top;
   logic        clk = 0, nrst = 0, read = 0, write = 0, haltMode = 0, cmpRawOut = 0;
   logic        pwmChannelOneIn = 0, cmpPowerOn, padToPadMode, padToRefMode, waitrequest;
   logic        posSelValid, portBLine3Out, portBLine3Oe, pwmChannelOneOut, cmpIntFlagOut;
   logic [3:0]  address = 0, refLevel;
   logic [7:0]  c;
   logic [13:0] posPadSel, negPadSel;
   logic [31:0] writedata = 0, readdata, q;
   int          nErrors = 0, numChecks = 0, cyc = 0;

   vcc_comparator_ctrl i_vcc_comparator_ctrl (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
      .readdata(readdata), .waitrequest(waitrequest), .haltMode(haltMode),
      .cmpRawOut(cmpRawOut), .pwmChannelOneIn(pwmChannelOneIn), .cmpPowerOn(cmpPowerOn),
      .padToPadMode(padToPadMode), .padToRefMode(padToRefMode), .refLevel(refLevel),
      .posSelValid(posSelValid), .posPadSel(posPadSel), .negPadSel(negPadSel),
      .portBLine3Out(portBLine3Out), .portBLine3Oe(portBLine3Oe),
      .pwmChannelOneOut(pwmChannelOneOut), .cmpIntFlagOut(cmpIntFlagOut));

   // Clock and hang limit
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         nErrors++;
         closeOut();
      end
   end

   // Expected {valid, positive, negative} selects for a control byte
   function automatic logic [28:0] expSel(input logic [7:0] v);
      logic [3:0] p;
      p = v[7:4];
      if (v[3:0] == 4'h0)
         return {1'b1, 14'h1 << ((p[3] ? 10 : 0) + p[1:0]),
                 14'h1 << ((p[2] ? 10 : 0) + (p[1:0] ^ 2'h1))};
      return {p < 14, p < 14 ? 14'h1 << p : 14'h0, 14'h0};
   endfunction

   // One bus access, held until waitrequest is seen low at an edge
   task automatic acc(input bit w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk);
      read      <= !w;
      write     <= w;
      address   <= a;
      writedata <= d;
      do @(posedge clk); while (waitrequest !== 1'b0);
      r = readdata;
      read  <= 1'h0;
      write <= 1'h0;
   endtask

   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      numChecks++;
      if (s !== e) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask

   task closeOut;
      $display("checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // Main sequence
   initial begin
      q = $urandom(32'h90B8E44A);
      repeat (16) @(posedge clk);
      nrst <= 1;
      for (int a = 0; a < 16; a += 2) begin
         acc(0, a[3:0], 0, q);
         chk("reset read", q, 0);
      end
      chk("power", cmpPowerOn, 0);
      $display("test reset done");
      acc(1, `VCC_ANALOG_ENABLE_OFS, 32'h80, q);
      @(negedge clk) chk("power", cmpPowerOn, 1);
      @(posedge clk) haltMode <= 1;
      @(negedge clk) chk("power", cmpPowerOn, 0);
      @(posedge clk) haltMode <= 0;
      $display("test power done");
      for (int i = 0; i < 48; i++) begin
         c = {i[3:0], i < 16 ? 4'h0 : i < 32 ? 4'hF : 4'($urandom_range(15, 1))};
         acc(1, `VCC_CTRL_OFS, c, q);
         acc(0, `VCC_CTRL_OFS, 0, q);
         chk("ctrl", q, c);
         @(negedge clk) chk("mode", {padToPadMode, padToRefMode, refLevel},
                            {c[3:0] == 4'h0, c[3:0] != 4'h0, c[3:0]});
         chk("select", {posSelValid, posPadSel, negPadSel}, expSel(c));
      end
      $display("test routing done");
      acc(0, `VCC_STATUS_OFS, 0, q);
      acc(1, `VCC_INT_OFS, 32'h2, q);
      @(posedge clk) cmpRawOut <= 1;
      repeat (6) @(posedge clk);
      @(negedge clk) chk("flag", cmpIntFlagOut, 1);
      acc(0, `VCC_INT_OFS, 0, q);
      chk("int reg", q, 32'h3);
      acc(0, `VCC_STATUS_OFS, 0, q);
      chk("status", q, 32'h80);
      acc(1, `VCC_INT_OFS, 32'h2, q);
      repeat (4) @(negedge clk);
      chk("flag", cmpIntFlagOut, 0);
      $display("test flag done");
      @(posedge clk) pwmChannelOneIn <= 1'h1;
      @(negedge clk) chk("pwm free", {portBLine3Oe, pwmChannelOneOut}, 2'h3);
      acc(1, `VCC_STATUS_OFS, 32'hC0, q);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk) cmpRawOut <= 1'($urandom);
         repeat (4) @(posedge clk);
         @(negedge clk) chk("pad", {portBLine3Oe, portBLine3Out, pwmChannelOneOut},
                            {1'h0, cmpRawOut, 1'h0});
      end
      acc(0, `VCC_STATUS_OFS, 0, q);
      chk("status", q, {cmpRawOut, 7'h40});
      $display("test pad done");
      closeOut();
   end
endmodule
